// ---- hdl/scp_pkg.sv ----
// constants shared by both ends of the serial configuration port
package scp_pkg;
    // ==========================================================
    // word layout
    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    localparam int ADDR_W = 3;
    localparam int DIR_BIT = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 12;
    localparam logic [4:0] CNT_WORD = 5'h10;
    localparam logic [4:0] CNT_HEAD = 5'h04;
    localparam logic [4:0] CNT_OVER = 5'h11;
    // ==========================================================
    // register map of the device
    localparam logic [2:0] ADDR_FAULT_A = 3'h0;
    localparam logic [2:0] ADDR_FAULT_B = 3'h1;
    localparam logic [2:0] ADDR_CTRL = 3'h2;
    localparam logic [2:0] ADDR_CFG_BEMF = 3'h3;
    localparam logic [2:0] ADDR_MAX = 3'h5;
    localparam int REG_N = 6;
    localparam logic [11:0] FAULT_A_MASK = 12'hdf7;
    localparam logic [11:0] FAULT_B_MASK = 12'hff8;
    localparam logic [11:0] CTRL_RST = 12'h3a4;
    localparam logic [11:0] CFG_RST = 12'h000;
    localparam logic [11:0] ZERO12 = 12'h000;
    localparam int CLR_BIT = 11;
    localparam int LOCK_HI = 10;
    localparam int LOCK_LO = 8;
    localparam int KEEP_HI = 7;
    localparam int DT_HI = 3;
    localparam int DT_LO = 2;
    localparam int BEMF_BIT = 0;
    localparam logic [2:0] LOCK_SET = 3'h6;
    localparam logic [2:0] LOCK_OPEN = 3'h3;
    localparam logic [2:0] STRAP_SETTLE = 3'h7;
    // ==========================================================
    // link timing, mclk at 4 ns
    localparam int MCLK_NS = 4;
    localparam int T_HALF_NS = 100;
    localparam int T_SETUP_NS = 100;
    localparam int T_HOLD_NS = 100;
    localparam int T_GAP_NS = 400;
    localparam int T_READY_MS = 2;
    localparam int HALF_CYC = (T_HALF_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int SETUP_CYC = (T_SETUP_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int GAP_CYC = (T_GAP_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int READY_CYC = (T_READY_MS * 1000000 + MCLK_NS - 1) / MCLK_NS;
    // ==========================================================
    // host command registers on wishbone
    localparam logic [3:0] WB_CMD = 4'h0;
    localparam logic [3:0] WB_STAT = 4'h4;
    localparam logic [3:0] WB_RX = 4'h8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_READY = 1;
    localparam logic [3:0] BIT_LAST = 4'hf;

    typedef enum logic [2:0] {
        SCP_IDLE = 3'h0,
        SCP_SETUP = 3'h1,
        SCP_HIGH = 3'h3,
        SCP_LOW = 3'h2,
        SCP_HOLD = 3'h6,
        SCP_GAP = 3'h4
    } scp_state_t;
endpackage

// ---- hdl/scp_if.sv ----
// four-wire serial link between controller and device
`timescale 1ns/1ps
interface scp_if;
    logic serial_clk;
    logic serial_select_n;
    logic serial_data_in;
    logic data_out_drv;
    logic data_out_oe;
    logic serial_data_out;

    // undriven output line settles low
    assign serial_data_out = data_out_oe ? data_out_drv : 1'b0;

    modport device (
        input serial_clk,
        input serial_select_n,
        input serial_data_in,
        output data_out_drv,
        output data_out_oe
    );
    modport host (
        output serial_clk,
        output serial_select_n,
        output serial_data_in,
        input serial_data_out
    );
endinterface

// ---- hdl/scp_sync.sv ----
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module scp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            level_q <= RST_VAL;
        else if (s2_q == s3_q)
            level_q <= s3_q;
    end

    assign level = level_q;
endmodule

// ---- hdl/scp_device.sv ----
// device end: serial slave port and its configuration registers
// ==========================================================
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module scp_device (
    input wire logic mclk,
    input wire logic nrst,
    scp_if.device link,
    input wire logic interface_strap_pin,
    input wire logic [11:0] fault_event_a,
    input wire logic [11:0] fault_event_b,
    output logic serial_mode,
    output logic [11:0] fault_status_a,
    output logic [11:0] fault_status_b,
    output logic [11:0] control,
    output logic [1:0] dead_time_sel,
    output logic bemf_sense_en,
    output logic [11:0] config_3,
    output logic [11:0] config_4,
    output logic [11:0] config_5
);
    // ==========================================================
    // pin synchronisers
    logic clk_lvl;
    logic sel_n_lvl;
    logic din_lvl;
    logic strap_lvl;

    // samples the master's clock, select and data, and the strap pin
    scp_sync #(.RST_VAL(1'b0)) u_clk (.mclk(mclk), .nrst(nrst), .pin(link.serial_clk),
        .level(clk_lvl));
    scp_sync #(.RST_VAL(1'b1)) u_sel (.mclk(mclk), .nrst(nrst), .pin(link.serial_select_n),
        .level(sel_n_lvl));
    scp_sync #(.RST_VAL(1'b0)) u_din (.mclk(mclk), .nrst(nrst), .pin(link.serial_data_in),
        .level(din_lvl));
    scp_sync #(.RST_VAL(1'b0)) u_strap (.mclk(mclk), .nrst(nrst), .pin(interface_strap_pin),
        .level(strap_lvl));

    // ==========================================================
    // strap capture after reset release
    logic [2:0] settle_q;
    logic serial_mode_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            settle_q <= 3'h0;
            serial_mode_q <= 1'b0;
        end
        else if (settle_q != scp_pkg::STRAP_SETTLE)
        begin
            settle_q <= settle_q + 3'h1;
            if (settle_q == scp_pkg::STRAP_SETTLE - 3'h1)
                serial_mode_q <= strap_lvl;
        end
    end

    // ==========================================================
    // edge detection
    logic clk_prev_q;
    logic act_prev_q;
    logic active;
    logic clk_rise;
    logic clk_fall;
    logic frame_start;
    logic frame_end;

    assign active = ~sel_n_lvl & serial_mode_q;
    assign clk_rise = active & clk_lvl & ~clk_prev_q;
    assign clk_fall = active & ~clk_lvl & clk_prev_q;
    assign frame_start = active & ~act_prev_q;
    assign frame_end = ~active & act_prev_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            clk_prev_q <= 1'b0;
            act_prev_q <= 1'b0;
        end
        else
        begin
            clk_prev_q <= clk_lvl;
            act_prev_q <= active;
        end
    end

    // ==========================================================
    // receive shifter and bit counter
    logic [15:0] rx_q;
    logic [4:0] cnt_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_q <= 16'h0000;
            cnt_q <= 5'h00;
        end
        else if (frame_start)
        begin
            rx_q <= 16'h0000;
            cnt_q <= 5'h00;
        end
        else if (clk_fall)
        begin
            rx_q <= {rx_q[14:0], din_lvl};
            if (cnt_q != scp_pkg::CNT_OVER)
                cnt_q <= cnt_q + 5'h01;
        end
    end

    // ==========================================================
    // register file
    logic [11:0] regs_q [scp_pkg::REG_N];
    logic [2:0] addr;
    logic addr_ok;
    logic commit;
    logic locked;
    logic [11:0] wdata;
    logic [2:0] wlock;
    logic clr_fault;
    logic [11:0] rd_data;
    logic [2:0] head_addr;

    assign addr = rx_q[scp_pkg::ADDR_HI:scp_pkg::ADDR_LO];
    assign wdata = rx_q[scp_pkg::DATA_W-1:0];
    assign wlock = wdata[scp_pkg::LOCK_HI:scp_pkg::LOCK_LO];
    assign addr_ok = addr <= scp_pkg::ADDR_MAX;
    assign locked = regs_q[scp_pkg::ADDR_CTRL][scp_pkg::LOCK_HI:scp_pkg::LOCK_LO]
        == scp_pkg::LOCK_SET;
    // commit only at select rise with exactly sixteen bits, write flag low
    assign commit = frame_end & (cnt_q == scp_pkg::CNT_WORD) & ~rx_q[scp_pkg::DIR_BIT]
        & addr_ok;
    assign clr_fault = commit & ~locked & (addr == scp_pkg::ADDR_CTRL)
        & wdata[scp_pkg::CLR_BIT];
    // after four falls the address sits in the low bits of the shifter
    assign head_addr = rx_q[scp_pkg::ADDR_W-1:0];
    assign rd_data = (head_addr <= scp_pkg::ADDR_MAX) ? regs_q[head_addr]
        : scp_pkg::ZERO12;

    // fault flags: a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            regs_q[scp_pkg::ADDR_FAULT_A] <= scp_pkg::ZERO12;
            regs_q[scp_pkg::ADDR_FAULT_B] <= scp_pkg::ZERO12;
        end
        else
        begin
            regs_q[scp_pkg::ADDR_FAULT_A] <= (clr_fault ? scp_pkg::ZERO12
                : regs_q[scp_pkg::ADDR_FAULT_A])
                | (fault_event_a & scp_pkg::FAULT_A_MASK);
            regs_q[scp_pkg::ADDR_FAULT_B] <= (clr_fault ? scp_pkg::ZERO12
                : regs_q[scp_pkg::ADDR_FAULT_B])
                | (fault_event_b & scp_pkg::FAULT_B_MASK);
        end
    end

    // control word: lock field takes only LOCK_SET or LOCK_OPEN, even when locked; clear bit never stored
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            regs_q[scp_pkg::ADDR_CTRL] <= scp_pkg::CTRL_RST;
        else if (commit && addr == scp_pkg::ADDR_CTRL)
        begin
            if (wlock == scp_pkg::LOCK_SET || wlock == scp_pkg::LOCK_OPEN)
                regs_q[scp_pkg::ADDR_CTRL][scp_pkg::LOCK_HI:scp_pkg::LOCK_LO]
                    <= wlock;
            if (!locked)
                regs_q[scp_pkg::ADDR_CTRL][scp_pkg::KEEP_HI:0]
                    <= wdata[scp_pkg::KEEP_HI:0];
        end
    end

    // plain configuration words, bemf enable starts cleared
    for (genvar i = scp_pkg::ADDR_CFG_BEMF; i < scp_pkg::REG_N; i++)
    begin : g_cfg
        always_ff @(posedge mclk or negedge nrst)
        begin
            if (!nrst)
                regs_q[i] <= scp_pkg::CFG_RST;
            else if (commit && !locked && addr == 3'(i))
                regs_q[i] <= wdata;
        end
    end

    // ==========================================================
    // transmit shifter
    logic [11:0] tx_q;
    logic dout_q;
    logic oe_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_q <= scp_pkg::ZERO12;
            dout_q <= 1'b0;
        end
        else if (frame_start)
        begin
            tx_q <= scp_pkg::ZERO12;
            dout_q <= 1'b0;
        end
        else if (clk_rise)
        begin
            if (cnt_q == scp_pkg::CNT_HEAD)
            begin
                // current contents, so a write returns the old value
                dout_q <= rd_data[scp_pkg::DATA_W-1];
                tx_q <= {rd_data[scp_pkg::DATA_W-2:0], 1'b0};
            end
            else if (cnt_q > scp_pkg::CNT_HEAD)
            begin
                dout_q <= tx_q[scp_pkg::DATA_W-1];
                tx_q <= {tx_q[scp_pkg::DATA_W-2:0], 1'b0};
            end
            else
                dout_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            oe_q <= 1'b0;
        else
            oe_q <= active;
    end

    // ==========================================================
    // outputs
    assign link.data_out_drv = dout_q;
    assign link.data_out_oe = oe_q;
    assign serial_mode = serial_mode_q;
    assign fault_status_a = regs_q[scp_pkg::ADDR_FAULT_A];
    assign fault_status_b = regs_q[scp_pkg::ADDR_FAULT_B];
    assign control = regs_q[scp_pkg::ADDR_CTRL];
    assign dead_time_sel = regs_q[scp_pkg::ADDR_CTRL][scp_pkg::DT_HI:scp_pkg::DT_LO];
    assign bemf_sense_en = regs_q[scp_pkg::ADDR_CFG_BEMF][scp_pkg::BEMF_BIT];
    assign config_3 = regs_q[3];
    assign config_4 = regs_q[4];
    assign config_5 = regs_q[5];
endmodule

// ---- hdl/scp_host.sv ----
// controller end: wishbone slave that runs serial words on the link
`timescale 1ns/1ps
module scp_host #(
    parameter int unsigned READY_CYCLES = scp_pkg::READY_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    scp_if.host link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ==========================================================
    // wake-up wait
    logic [31:0] ready_cnt_q;
    logic ready_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ready_cnt_q <= 32'h0;
            ready_q <= 1'b0;
        end
        else if (!ready_q)
        begin
            ready_cnt_q <= ready_cnt_q + 32'h1;
            if (ready_cnt_q + 32'h1 >= READY_CYCLES)
                ready_q <= 1'b1;
        end
    end

    // ==========================================================
    // wishbone slave
    logic req;
    logic start;
    logic busy;
    logic [15:0] rx_q;
    logic [31:0] dat_q;
    logic ack_q;
    scp_pkg::scp_state_t state_q;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign busy = state_q != scp_pkg::SCP_IDLE;
    assign start = req & wb_we_i & (wb_adr_i[3:0] == scp_pkg::WB_CMD) & (&wb_sel_i[1:0])
        & ~busy & ready_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end
        else
        begin
            ack_q <= req;
            dat_q <= 32'h0;
            if (req && !wb_we_i)
            begin
                case (wb_adr_i[3:0])
                    scp_pkg::WB_STAT: dat_q <= {30'h0, ready_q, busy};
                    scp_pkg::WB_RX: dat_q <= {16'h0, rx_q};
                    default: dat_q <= 32'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // serial sequencer
    logic dout_lvl;
    logic [7:0] tmr_q;
    logic [3:0] bit_q;
    logic [15:0] tx_q;
    logic sclk_q;
    logic sel_n_q;
    logic sdi_q;

    scp_sync #(.RST_VAL(1'b0)) u_dout (.mclk(mclk), .nrst(nrst), .pin(link.serial_data_out),
        .level(dout_lvl));

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= scp_pkg::SCP_IDLE;
            tmr_q <= 8'h0;
            bit_q <= 4'h0;
            tx_q <= 16'h0;
            rx_q <= 16'h0;
            sclk_q <= 1'b0;
            sel_n_q <= 1'b1;
            sdi_q <= 1'b0;
        end
        else
        begin
            tmr_q <= tmr_q - 8'h1;
            case (state_q)
                scp_pkg::SCP_IDLE:
                begin
                    if (start)
                    begin
                        // clock already low when select falls
                        state_q <= scp_pkg::SCP_SETUP;
                        sel_n_q <= 1'b0;
                        tx_q <= wb_dat_i[15:0];
                        bit_q <= 4'h0;
                        tmr_q <= 8'(scp_pkg::SETUP_CYC - 1);
                    end
                end
                scp_pkg::SCP_SETUP, scp_pkg::SCP_LOW:
                begin
                    if (tmr_q == 8'h0)
                    begin
                        if (state_q == scp_pkg::SCP_LOW && bit_q == scp_pkg::BIT_LAST)
                        begin
                            state_q <= scp_pkg::SCP_HOLD;
                            tmr_q <= 8'(scp_pkg::HOLD_CYC - 1);
                        end
                        else
                        begin
                            if (state_q == scp_pkg::SCP_LOW)
                                bit_q <= bit_q + 4'h1;
                            state_q <= scp_pkg::SCP_HIGH;
                            sclk_q <= 1'b1;
                            sdi_q <= tx_q[15];
                            tx_q <= {tx_q[14:0], 1'b0};
                            tmr_q <= 8'(scp_pkg::HALF_CYC - 1);
                        end
                    end
                end
                scp_pkg::SCP_HIGH:
                begin
                    if (tmr_q == 8'h0)
                    begin
                        state_q <= scp_pkg::SCP_LOW;
                        sclk_q <= 1'b0;
                        rx_q <= {rx_q[14:0], dout_lvl};
                        tmr_q <= 8'(scp_pkg::HALF_CYC - 1);
                    end
                end
                scp_pkg::SCP_HOLD:
                begin
                    if (tmr_q == 8'h0)
                    begin
                        // sixteen clocks done, release with clock low
                        state_q <= scp_pkg::SCP_GAP;
                        sel_n_q <= 1'b1;
                        tmr_q <= 8'(scp_pkg::GAP_CYC - 1);
                    end
                end
                scp_pkg::SCP_GAP:
                begin
                    if (tmr_q == 8'h0)
                        state_q <= scp_pkg::SCP_IDLE;
                end
                default: state_q <= scp_pkg::SCP_IDLE;
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign link.serial_clk = sclk_q;
    assign link.serial_select_n = sel_n_q;
    assign link.serial_data_in = sdi_q;
    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
endmodule

// ---- tb/scp_link_assertions.sv ----
// link checker for the serial configuration port
`timescale 1ns/1ps
module scp_link_assertions (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    input wire logic data_out_drv,
    input wire logic data_out_oe,
    input wire logic serial_data_out
);
    // ==========================================================
    // helper counters
    logic [7:0] hi_cnt_q;
    logic [4:0] rise_n_q;
    logic [3:0] rise_age_q;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            hi_cnt_q <= 8'hff;
        else if (!serial_select_n)
            hi_cnt_q <= 8'h00;
        else if (hi_cnt_q != 8'hff)
            hi_cnt_q <= hi_cnt_q + 8'h01;
    end
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rise_n_q <= 5'h00;
            rise_age_q <= 4'h0;
        end
        else if (serial_select_n)
            rise_n_q <= 5'h00;
        else if ($rose(serial_clk))
        begin
            rise_n_q <= rise_n_q + 5'h01;
            rise_age_q <= 4'h0;
        end
        else if (rise_age_q != 4'hf)
            rise_age_q <= rise_age_q + 4'h1;
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    a_oe_desel: assert property (serial_select_n [*8] |-> !data_out_oe)
        else $error("output enabled while deselected");
    a_clk_idle: assert property ($changed(serial_select_n) || serial_select_n |-> !serial_clk)
        else $error("link clock high at select edge");
    a_sel_gap: assert property ($fell(serial_select_n) |-> hi_cnt_q >= 8'h64)
        else $error("select idle gap too short");
    a_dout_on_rise: assert property ($changed(data_out_drv) && data_out_oe && rise_n_q != 5'h00
        |-> rise_age_q <= 4'h8)
        else $error("output bit changed away from clock rise");
    a_head_zero: assert property (data_out_oe && rise_n_q >= 5'h01 && rise_n_q <= 5'h04
        && rise_age_q >= 4'h8 |-> !serial_data_out)
        else $error("header bits of output not zero");
    a_word_bits: assert property ($rose(serial_select_n) |-> rise_n_q == 5'h10)
        else $error("frame without sixteen clocks");
    a_sdi_setup: assert property ($fell(serial_clk) |-> serial_data_in == $past(serial_data_in, 8))
        else $error("input bit moved before falling edge");
    a_sdi_hold: assert property ($fell(serial_clk) |=> $stable(serial_data_in) [*8])
        else $error("input bit moved after falling edge");
    c_frame: cover property ($rose(serial_select_n) && rise_n_q == 5'h10);
    c_out_one: cover property (data_out_oe && serial_data_out);
    c_start: cover property ($fell(serial_select_n));
endmodule

// ---- tb/spi_slave_config_port_tb_top.sv ----
// testbench: host and device ends joined over the link
`timescale 1ns/1ps
module spi_slave_config_port_tb_top;
    // ==========================================================
    // signals
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [31:0] wb_adr = 32'h00000000;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat = 32'h00000000;
    logic strap = 1'b1;
    logic [11:0] fev_a = 12'h000;
    logic [11:0] fev_b = 12'h000;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic smode;
    logic bemf;
    logic [1:0] dts;
    logic [11:0] fsa, fsb, ctl, c3, c4, c5;
    logic [15:0] rx;
    logic [31:0] q;
    logic [46:0] rows [16];
    int err_count = 0;
    int samples_checked = 0;
    int cyc_cnt = 0;
    always #2 mclk = ~mclk;
    // ==========================================================
    // instances
    scp_if scp_if_inst ();
    scp_device scp_device_inst (.mclk(mclk), .nrst(nrst), .link(scp_if_inst),
        .interface_strap_pin(strap), .fault_event_a(fev_a), .fault_event_b(fev_b),
        .serial_mode(smode), .fault_status_a(fsa), .fault_status_b(fsb), .control(ctl),
        .dead_time_sel(dts), .bemf_sense_en(bemf), .config_3(c3), .config_4(c4), .config_5(c5));
    scp_host #(.READY_CYCLES(20)) scp_host_inst (.mclk(mclk), .nrst(nrst), .link(scp_if_inst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
    scp_link_assertions scp_link_assertions_inst (.mclk(mclk), .nrst(nrst),
        .serial_clk(scp_if_inst.serial_clk), .serial_select_n(scp_if_inst.serial_select_n),
        .serial_data_in(scp_if_inst.serial_data_in), .data_out_drv(scp_if_inst.data_out_drv),
        .data_out_oe(scp_if_inst.data_out_oe), .serial_data_out(scp_if_inst.serial_data_out));
    // ==========================================================
    // tasks
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [15:0] d,
        output logic [31:0] r);
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {28'h0000000, adr};
        wb_dat <= {16'h0000, d};
        do
        begin
            @(posedge mclk);
        end
        while (wb_ack !== 1'b1);
        r = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        logic [31:0] s;
        wb(1'b1, scp_pkg::WB_CMD, w, s);
        do
        begin
            wb(1'b0, scp_pkg::WB_STAT, 16'h0000, s);
        end
        while (s[scp_pkg::STAT_BUSY] !== 1'b0);
        wb(1'b0, scp_pkg::WB_RX, 16'h0000, s);
        r = s[15:0];
    endtask
    task automatic wait_ready();
        logic [31:0] s;
        do
        begin
            wb(1'b0, scp_pkg::WB_STAT, 16'h0000, s);
        end
        while (s[scp_pkg::STAT_READY] !== 1'b1);
    endtask
    function automatic logic [11:0] regv(input logic [2:0] a);
        case (a)
            3'h0: return fsa;
            3'h1: return fsb;
            3'h2: return ctl;
            3'h3: return c3;
            3'h4: return c4;
            default: return c5;
        endcase
    endfunction
    // ==========================================================
    // timeout and main sequence
    always @(posedge mclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 60000)
        begin
            err_count++;
            test_done();
        end
    end
    initial
    begin
        rows = '{{16'ha000, 16'h03a4, 3'h2, 12'h3a4}, {16'h35a5, 16'h0000, 3'h3, 12'h5a5},
            {16'h3a5a, 16'h05a5, 3'h3, 12'ha5a}, {16'h4fff, 16'h0000, 3'h4, 12'hfff},
            {16'h5001, 16'h0000, 3'h5, 12'h001}, {16'hb000, 16'h0a5a, 3'h3, 12'ha5a},
            {16'h6123, 16'h0000, 3'h5, 12'h001}, {16'hf000, 16'h0000, 3'h4, 12'hfff},
            {16'h8000, 16'h0df7, 3'h0, 12'hdf7}, {16'h9000, 16'h0ff8, 3'h1, 12'hff8},
            {16'h2ba4, 16'h03a4, 3'h0, 12'h000}, {16'h26a4, 16'h03a4, 3'h2, 12'h6a4},
            {16'h3111, 16'h0a5a, 3'h3, 12'ha5a}, {16'h21a4, 16'h06a4, 3'h2, 12'h6a4},
            {16'h23a4, 16'h06a4, 3'h2, 12'h3a4}, {16'h3111, 16'h0a5a, 3'h3, 12'h111}};
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        wait_ready();
        chk("strap view", {12'h000, smode, dts, bemf}, 16'h000a);
        @(posedge mclk);
        fev_a <= 12'hfff;
        fev_b <= 12'hfff;
        @(posedge mclk);
        fev_a <= 12'h000;
        fev_b <= 12'h000;
        for (int i = 0; i < 16; i++)
        begin
            xfer(rows[i][46:31], rx);
            chk("rx word", rx, rows[i][30:15]);
            chk("register", {4'h0, regv(rows[i][14:12])}, {4'h0, rows[i][11:0]});
        end
        chk("bemf enable", {15'h0000, bemf}, 16'h0001);
        chk("fault b", {4'h0, fsb}, 16'h0000);
        wb(1'b0, 4'hc, 16'h0000, q);
        chk("unmapped read", q[15:0], 16'h0000);
        wb(1'b1, scp_pkg::WB_CMD, 16'h5abc, q);
        xfer(16'h4123, rx);
        chk("refused word", {4'h0, c4}, 16'h0fff);
        chk("old contents", rx, 16'h0001);
        chk("config 5", {4'h0, c5}, 16'h0abc);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        wb(1'b1, scp_pkg::WB_CMD, 16'h3fff, q);
        wb(1'b0, scp_pkg::WB_STAT, 16'h0000, q);
        chk("early busy", {15'h0000, q[scp_pkg::STAT_BUSY]}, 16'h0000);
        wait_ready();
        chk("control reset", {4'h0, ctl}, 16'h03a4);
        chk("strap again", {12'h000, smode, dts, bemf}, 16'h000a);
        xfer(16'hb000, rx);
        chk("config 3 reset", rx, 16'h0000);
        @(posedge mclk);
        strap <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        wait_ready();
        xfer(16'h3555, rx);
        chk("strap low", {3'h0, smode, c3}, 16'h0000);
        chk("strap low rx", rx, 16'h0000);
        test_done();
    end
endmodule
